/* File: hw/char_fifo.v */
// Purpose: small synchronous fifo for response characters
// Assumes: one clock, active-low synchronous-released reset
// Notes: full and empty are exact; out_valid is decoded from the count register
module char_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
)(
  input wire clk, // clock
  input wire rst_n, // reset, active low
  input wire [WIDTH-1:0] in_data, // write data
  input wire in_valid, // write request
  output wire in_ready, // not full
  output wire [WIDTH-1:0] out_data, // head data
  output wire out_valid, // not empty
  input wire out_ready // sink takes head
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0] cnt_q;
  wire wr;
  wire rd;
  assign in_ready = (cnt_q != DEPTH);
  assign out_valid = (cnt_q != 0);
  assign out_data = mem[rp_q];
  assign wr = in_valid && in_ready;
  assign rd = out_valid && out_ready;
  always @(posedge clk)
  begin
    if (wr)
    begin
      mem[wp_q] <= in_data;
    end
  end
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (wr)
      begin
        wp_q <= (wp_q == DEPTH-1) ? {AW{1'b0}} : wp_q + 1'b1;
      end
      if (rd)
      begin
        rp_q <= (rp_q == DEPTH-1) ? {AW{1'b0}} : rp_q + 1'b1;
      end
      if (wr && !rd)
      begin
        cnt_q <= cnt_q + 1'b1;
      end
      else if (rd && !wr)
      begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

/* File: hw/cmd_status_map.vh */
// Purpose: constants for the host command interpreter
// Assumes: 8-bit ascii characters, one per cycle
// Notes: response text bytes are ascii codes
`ifndef CMD_STATUS_MAP_VH
`define CMD_STATUS_MAP_VH
`define CH_TILDE 8'h7e
`define CH_SLASH 8'h2f
`define CH_HASH 8'h23
`define CH_SPACE 8'h20
`define CH_ZERO 8'h30
`define CH_ONE 8'h31
`define CH_CR 8'h0d
`define CMD_DIAG 8'h34
`define CMD_STATUS 8'h35
`define CMD_RESET 8'h3b
`define CMD_CLEAR 8'h3c
`define CMD_LOCAL_LIMIT 8'h41
`define FLAG_COUNT 22
`define DIGIT_COUNT 5
`define ID_LEN 3
`define STATUS_LEN 29
`define DIAG_LEN 10
`endif

/* File: hw/host_command_status_reporter.v */
// Purpose: decode host command characters and answer diagnostic and status requests
// Assumes: one received character per rx_valid pulse; 100 MHz clock
// Notes: replies pass through an 8-deep fifo; tx side may stall
`include "cmd_status_map.vh"

// What this block does
// - serial ports: commands recognised only in the character after a tilde framing character; the closing tilde must arrive before the next command.
// - network ports: slash prefixes command; unprefixed A-or-above goes to user program.
// - characters below 65 run locally; 65 and above forwarded as data.
// - command 52 returns id, hash sign and five-digit message count.
// - 16-bit message count increments on each diagnostic-string command accepted while no reply is pending.
// - count clears on clear command 60, reset command 59, power-up.
// - command 53 returns id, two-character version and 22 status flags.
// - status positions A to V are digit 1 when condition holds.
// - inzone and outzone follow entry and exit presence sensors.
// - zone error on double entry or exit without entry.
// - decode and buffer-lag flags reflect decoder activity and backlog.
// - scan speed flag set when mirror speed out of range.
// - transmit flag set while any port sends data.
// - receive flag set while data arrives on host, setup or network.
// - receive error flag on parity or framing error.
// - nak flag when network not polling or controller data erroneous.
// - no-read, match, no-match flags follow energized outputs.
// - setup, program and default flags follow operating modes.
// - fault, stall and reverse flags follow hardware conditions.
// - ethernet-fail, network-fail and slave-offline flags follow network state.
// - command 59 clears the count and pulses restart_req for one cycle; zone error and reply state are kept until nrst.
module host_command_status_reporter #(
  parameter [23:0] ID_TEXT = 24'h444556, // arbitrary identification text
  parameter [15:0] VERSION_TEXT = 16'h3130, // arbitrary version text
  parameter FIFO_DEPTH = 8
)(
  input wire clk, // system clock
  input wire nrst, // reset, active low
  input wire [7:0] rx_char, // received character
  input wire rx_valid, // character strobe
  input wire rx_network, // 1: network port, 0: serial port
  input wire rx_start, // network: first character of a string
  input wire [21:0] flags_in, // live status conditions, bit 21 = position a
  input wire entry_evt, // entry sensor pulse
  input wire exit_evt, // exit sensor pulse
  input wire tx_ready, // reply sink accepts
  output reg [7:0] tx_char, // reply character
  output reg tx_valid, // reply character valid
  output reg [7:0] user_char, // data to user program
  output reg user_valid, // user data strobe
  output reg restart_req, // full restart pulse
  output reg zone_err, // zone error sticky flag
  output reg [15:0] msg_count // message count
);
  localparam S_IDLE = 2'h0;
  localparam S_CMD = 2'h1;
  localparam S_TRAIL = 2'h2;
  localparam S_DATA = 2'h3;
  localparam K_NONE = 2'h0;
  localparam K_DIAG = 2'h1;
  localparam K_STAT = 2'h2;

  reg r1_q;
  reg rst_n;
  reg [1:0] st_q;
  reg [1:0] kind_q;
  reg [4:0] idx_q;
  reg [21:0] snap_q;
  reg [15:0] cnt_snap_q;
  reg zone_in_q;
  wire [7:0] f_data;
  wire f_ready;
  wire [7:0] h_data;
  wire h_valid;
  reg [7:0] byte_d;

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      r1_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      r1_q <= 1'b1;
      rst_n <= r1_q;
    end
  end

  // decimal digit n (0 = most significant) of a 16-bit value
  function [7:0] dec_digit;
    input [15:0] v;
    input [4:0] n;
    reg [15:0] q;
    reg [15:0] r;
    begin
      q = v;
      case (n)
        5'h0: q = v / 16'd10000;
        5'h1: q = v / 16'd1000;
        5'h2: q = v / 16'd100;
        5'h3: q = v / 16'd10;
        default: q = v;
      endcase
      r = q % 16'd10;
      dec_digit = `CH_ZERO + r[7:0];
    end
  endfunction

  // ------------------------------------------------------------
  // reply byte selection
  // ------------------------------------------------------------
  always @*
  begin
    byte_d = `CH_SPACE;
    if (idx_q < `ID_LEN)
    begin
      byte_d = ID_TEXT[8*(`ID_LEN-1-idx_q) +: 8];
    end
    else if (idx_q == `ID_LEN)
    begin
      byte_d = `CH_SPACE;
    end
    else if (kind_q == K_DIAG)
    begin
      // diag hash
      if (idx_q == `ID_LEN + 1)
      begin
        byte_d = `CH_HASH;
      end
      else
      begin
        byte_d = dec_digit(cnt_snap_q, idx_q - 5'd5);
      end
    end
    else
    begin
      if (idx_q < 5'd6)
      begin
        byte_d = VERSION_TEXT[8*(5 - idx_q) +: 8];
      end
      else if (idx_q == 5'd6)
      begin
        byte_d = `CH_SPACE;
      end
      else
      begin
        byte_d = snap_q[`FLAG_COUNT - 1 - (idx_q - 5'd7)] ? `CH_ONE : `CH_ZERO;
      end
    end
  end

  // ------------------------------------------------------------
  // command decode and reply sequencing
  // ------------------------------------------------------------
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= S_IDLE;
      kind_q <= K_NONE;
      idx_q <= 5'h0;
      snap_q <= 22'h0;
      cnt_snap_q <= 16'h0;
      msg_count <= 16'h0;
      user_char <= 8'h0;
      user_valid <= 1'b0;
      restart_req <= 1'b0;
      zone_in_q <= 1'b0;
      zone_err <= 1'b0;
    end
    else
    begin
      user_valid <= 1'b0;
      restart_req <= 1'b0;
      if (entry_evt)
      begin
        if (zone_in_q && !exit_evt)
        begin
          zone_err <= 1'b1;
        end
        zone_in_q <= 1'b1;
      end
      else if (exit_evt)
      begin
        if (!zone_in_q)
        begin
          zone_err <= 1'b1;
        end
        zone_in_q <= 1'b0;
      end
      if (kind_q != K_NONE && f_ready)
      begin
        if (idx_q == ((kind_q == K_DIAG) ? `DIAG_LEN - 1 : `STATUS_LEN - 1))
        begin
          kind_q <= K_NONE;
          idx_q <= 5'h0;
        end
        else
        begin
          idx_q <= idx_q + 1'b1;
        end
      end
      if (rx_valid)
      begin
        if (rx_network && rx_start)
        begin
          st_q <= (rx_char == `CH_SLASH) ? S_CMD : S_DATA;
          if (rx_char != `CH_SLASH && rx_char >= `CMD_LOCAL_LIMIT)
          begin
            user_char <= rx_char;
            user_valid <= 1'b1;
          end
        end
        else
        begin
          case (st_q)
            S_IDLE:
            begin
              if (!rx_network && rx_char == `CH_TILDE)
              begin
                st_q <= S_CMD;
              end
            end
            S_CMD:
            begin
              if (rx_char >= `CMD_LOCAL_LIMIT)
              begin
                user_char <= rx_char;
                user_valid <= 1'b1;
                st_q <= rx_network ? S_DATA : S_TRAIL;
              end
              else if (!rx_network && rx_char == `CH_TILDE)
              begin
                st_q <= S_CMD;
              end
              else
              begin
                st_q <= rx_network ? S_DATA : S_TRAIL;
                if (rx_char == `CMD_DIAG && kind_q == K_NONE)
                begin
                  kind_q <= K_DIAG;
                  cnt_snap_q <= msg_count;
                  msg_count <= msg_count + 1'b1;
                end
                else if (rx_char == `CMD_STATUS && kind_q == K_NONE)
                begin
                  kind_q <= K_STAT;
                  snap_q <= {flags_in[21:20], zone_err, flags_in[18:0]};
                end
                else if (rx_char == `CMD_CLEAR)
                begin
                  msg_count <= 16'h0;
                end
                else if (rx_char == `CMD_RESET)
                begin
                  msg_count <= 16'h0;
                  restart_req <= 1'b1;
                end
              end
            end
            S_TRAIL:
            begin
              if (rx_char == `CH_TILDE)
              begin
                st_q <= S_IDLE;
              end
            end
            default:
            begin
              if (rx_network && rx_char >= `CMD_LOCAL_LIMIT)
              begin
                user_char <= rx_char;
                user_valid <= 1'b1;
              end
              if (!rx_network)
              begin
                st_q <= (rx_char == `CH_TILDE) ? S_CMD : S_IDLE;
              end
            end
          endcase
        end
      end
    end
  end

  // ------------------------------------------------------------
  // reply buffer and registered output
  // ------------------------------------------------------------
  char_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(3)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_data(byte_d),
    .in_valid(kind_q != K_NONE),
    .in_ready(f_ready),
    .out_data(f_data),
    .out_valid(h_valid),
    .out_ready(!tx_valid || tx_ready)
  );
  assign h_data = f_data;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_char <= 8'h0;
      tx_valid <= 1'b0;
    end
    else if (!tx_valid || tx_ready)
    begin
      tx_char <= h_data;
      tx_valid <= h_valid;
    end
  end
endmodule

/* File: verification/host_cmd_props.sv */
// Purpose: port checks for the host command reporter
// Assumes: one clock, nrst active low
// Notes: bound to the design from the bench top file
module host_cmd_props (
  input wire clk, // clock
  input wire nrst, // reset, active low
  input wire entry_evt, // entry pulse
  input wire exit_evt, // exit pulse
  input wire tx_ready, // sink ready
  input wire [7:0] tx_char, // reply char
  input wire tx_valid, // reply valid
  input wire [7:0] user_char, // user data
  input wire user_valid, // user strobe
  input wire restart_req, // restart pulse
  input wire zone_err, // zone error
  input wire [15:0] msg_count // message count
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence count_step;
    msg_count == $past(msg_count) + 16'h0001;
  endsequence
  sequence reply_starts;
    ##[1:6] tx_valid;
  endsequence
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_char))
    else $error("reply char lost while stalled");
  diag_reply_a: assert property (count_step |-> reply_starts)
    else $error("no reply after count step");
  count_move_a: assert property ($changed(msg_count) |->
    msg_count == $past(msg_count) + 16'h0001 || msg_count == 16'h0000)
    else $error("count moved by other than one");
  power_zero_a: assert property ($rose(nrst) |-> msg_count == 16'h0000 && !zone_err)
    else $error("state not clear after reset");
  restart_clear_a: assert property (restart_req |-> ##[0:3] msg_count == 16'h0000)
    else $error("count not cleared on restart");
  restart_pulse_a: assert property (restart_req |=> !restart_req)
    else $error("restart longer than one cycle");
  user_range_a: assert property (user_valid |-> user_char >= 8'h41)
    else $error("local code sent to user");
  zone_keep_a: assert property (zone_err |=> zone_err)
    else $error("zone error dropped");
  zone_cause_a: assert property ($rose(zone_err) |-> $past(entry_evt) || $past(exit_evt)
    || $past(entry_evt, 2) || $past(exit_evt, 2) || $past(entry_evt, 3) || $past(exit_evt, 3))
    else $error("zone error without sensor");
endmodule

/* File: verification/host_command_status_reporter_bench.sv */
// Purpose: command and reply checks for the host command reporter
// Assumes: 100 MHz clock, nrst held 8 cycles
// Notes: replies collected by reply_sink
module host_command_status_reporter_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] rx_char = 8'h00;
  logic rx_valid = 1'b0;
  logic rx_network = 1'b0;
  logic rx_start = 1'b0;
  logic [21:0] flags_in = 22'h000000;
  logic entry_evt = 1'b0;
  logic exit_evt = 1'b0;
  logic slow = 1'b0;
  wire tx_ready, tx_valid, user_valid, restart_req, zone_err;
  wire [7:0] tx_char, user_char;
  wire [15:0] msg_count;
  int err_count = 0;
  int total_checks = 0;
  int restarts = 0;
  logic [7:0] uq[$];
  always #5 clk = ~clk;
  host_command_status_reporter i_host_command_status_reporter (.clk, .nrst, .rx_char, .rx_valid, .rx_network,
    .rx_start, .flags_in, .entry_evt, .exit_evt, .tx_ready, .tx_char, .tx_valid, .user_char, .user_valid,
    .restart_req, .zone_err, .msg_count);
  reply_sink i_reply_sink (.clk, .slow, .tx_valid, .tx_char, .tx_ready);
  always @(posedge clk)
  begin
    if (user_valid === 1'b1)
      uq.push_back(user_char);
    if (restart_req === 1'b1)
      restarts++;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic put(input logic [7:0] c, input logic s);
    rx_char <= c;
    rx_valid <= 1'b1;
    rx_start <= s;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_start <= 1'b0;
    @(posedge clk);
  endtask
  task automatic ser(input logic [7:0] c);
    rx_network <= 1'b0;
    put(8'h7e, 1'b0);
    put(c, 1'b0);
    put(8'h7e, 1'b0);
  endtask
  task automatic net(input logic [7:0] c);
    rx_network <= 1'b1;
    put(8'h2f, 1'b1);
    put(c, 1'b0);
  endtask
  task automatic reply(input string s);
    int n;
    n = 0;
    while (i_reply_sink.got.size() < s.len() && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 400)
    begin
      err_count++;
      wrap_up();
    end
    repeat (4) @(posedge clk);
    chk(i_reply_sink.got.size(), s.len());
    foreach (s[i]) chk(i_reply_sink.got[i], s[i]);
    i_reply_sink.got.delete();
  endtask
  task automatic silent;
    repeat (12) @(posedge clk);
    chk(i_reply_sink.got.size(), 0);
  endtask
  function automatic string stat(input logic [21:0] f, input logic z);
    string s;
    s = "DEV 10 ";
    for (int i = 21; i >= 0; i--)
      s = {s, (((i == 19) ? z : f[i]) ? "1" : "0")};
    return s;
  endfunction
  initial
  begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    chk(msg_count, 16'h0000);
    ser(8'h34);
    reply("DEV #00000");
    chk(msg_count, 16'h0001);
    net(8'h34);
    reply("DEV #00001");
    chk(msg_count, 16'h0002);
    rx_network <= 1'b0;
    put(8'h34, 1'b0);
    silent();
    chk(msg_count, 16'h0002);
    ser(8'h30);
    silent();
    ser(8'h3c);
    chk(msg_count, 16'h0000);
    rx_network <= 1'b1;
    put(8'h41, 1'b1);
    ser(8'h42);
    chk(uq.size(), 2);
    chk(uq[0], 8'h41);
    chk(uq[1], 8'h42);
    flags_in <= 22'h2d5a5b;
    slow <= 1'b1;
    @(posedge clk);
    ser(8'h35);
    flags_in <= 22'h000000;
    reply(stat(22'h2d5a5b, 1'b0));
    for (int k = 0; k < 2; k++)
    begin
      chk(zone_err, 1'b0);
      entry_evt <= 1'b1;
      @(posedge clk);
      entry_evt <= 1'b0;
      repeat (3) @(posedge clk);
    end
    chk(zone_err, 1'b1);
    slow <= 1'b0;
    ser(8'h35);
    reply(stat(22'h000000, 1'b1));
    ser(8'h34);
    reply("DEV #00000");
    ser(8'h3b);
    chk(restarts, 1);
    chk(msg_count, 16'h0000);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    chk(zone_err, 1'b0);
    exit_evt <= 1'b1;
    @(posedge clk);
    exit_evt <= 1'b0;
    repeat (3) @(posedge clk);
    chk(zone_err, 1'b1);
    wrap_up();
  end
endmodule
bind host_command_status_reporter host_cmd_props i_host_cmd_props (.clk, .nrst, .entry_evt, .exit_evt, .tx_ready,
  .tx_char, .tx_valid, .user_char, .user_valid, .restart_req, .zone_err, .msg_count);

/* File: verification/reply_sink.sv */
// Purpose: host side sink for reply characters
// Assumes: tx_ready changes just after clk edges
// Notes: slow stalls every other cycle
module reply_sink (
  input wire clk, // clock
  input wire slow, // stall mode
  input wire tx_valid, // reply valid
  input wire [7:0] tx_char, // reply char
  output logic tx_ready // accept
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$];
  initial tx_ready = 1'b0;
  always @(posedge clk)
  begin
    if (tx_valid === 1'b1 && tx_ready)
      got.push_back(tx_char);
    tx_ready <= slow ? !tx_ready : 1'b1;
  end
endmodule
